// ==== src/pgcs_ctrl.v ====
`timescale 1ns/100ps
`include "pgcs_consts.vh"
// ----------------------------------------
// channel state and waveform write pointer control
// ----------------------------------------
module pgcs_ctrl
#(
   parameter NCH = 8, // channels
   parameter SW = 16, // sample width (one bit per channel used)
   parameter AW = 10, // memory address width
   parameter NLBL_LOG2 = 2, // label index width
   parameter HAS_OFF = 1, // variant with high impedance support
   parameter RW = 32 // rate word width
)
(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // pattern configuration, pending side
   input wire cfg_wr_i, // one-cycle pulse
   input wire cfg_sel_i, // 0 stopped, 1 startup
   input wire cfg_mask_form_i, // bit mask form
   input wire [NCH*`PGCS_ST_W-1:0] cfg_codes_i, // code per position
   input wire [NCH-1:0] cfg_mask_i, // mask form data
   input wire [NCH*4-1:0] channel_selection_i, // position -> channel
   input wire [4:0] cfg_len_i, // pattern length
   input wire [4:0] sel_count_i, // selected channel count
   output reg cfg_err_o,
   // rate
   input wire [RW-1:0] rate_cfg_i,
   input wire [RW-1:0] file_rate_i,
   input wire file_rate_flag_i,
   output reg [RW-1:0] active_rate_o,
   input wire commit_i,
   // generation control
   input wire start_i,
   input wire done_i,
   input wire pause_i, // pin level
   input wire underflow_i,
   // waveform write
   input wire wr_valid_i,
   output wire wr_ready_o,
   input wire [SW-1:0] wr_data_i,
   input wire [NLBL_LOG2-1:0] waveform_label_i,
   input wire wr_first_i, // first sample of a write
   input wire [AW:0] loaded_sample_count_i, // size of the write
   output reg wr_err_o,
   output reg [AW-1:0] mem_addr_o,
   output reg [SW-1:0] mem_data_o,
   output reg mem_we_o,
   output reg [AW:0] wr_ptr_o, // pointer of current label
   // sample path
   input wire smp_valid_i,
   input wire [NCH-1:0] smp_i,
   output reg [NCH-1:0] ch_o,
   output reg [NCH-1:0] ch_oe_o,
   output reg [1:0] gen_state_o
);
   localparam NL = 1 << NLBL_LOG2;
   localparam [AW:0] MEM_TOP = {1'b1, {AW{1'b0}}};
   // ----------------------------------------
   // pending and active pattern storage
   // ----------------------------------------
   reg [NCH*`PGCS_ST_W-1:0] stop_pend_r, start_pend_r, stop_act_r, start_act_r;
   reg [RW-1:0] rate_pend_r; // pending rate choice
   reg p0_r, p1_r; // pause synchroniser
   reg [1:0] gst_r; // generation state
   reg [AW:0] base_r [0:NL-1]; // region base
   reg [AW:0] size_r [0:NL-1]; // region size
   reg [AW:0] ptr_r [0:NL-1]; // next write offset
   reg [NL-1:0] alloc_r; // label allocated
   reg [AW:0] free_r; // next free address
   reg [NLBL_LOG2-1:0] lbl_r; // label of write in progress
   reg refuse_r; // current write refused
   integer i; // channel loop, pins process only
   integer ci; // position loop, pattern builder only
   integer li; // label loop, allocation reset only
   // decode one code, mapping off to hold where not supported
   function [1:0] eff_code;
      input [1:0] c;
      begin
         if (c == `PGCS_ST_OFF && HAS_OFF == 0)
            eff_code = `PGCS_ST_HOLD;
         else
            eff_code = c;
      end
   endfunction
   // ----------------------------------------
   // write path through the fifo
   // ----------------------------------------
   wire f_valid;
   wire [SW+NLBL_LOG2+AW+1:0] f_data;
   pgcs_fifo #(.WIDTH(SW+NLBL_LOG2+AW+2), .DEPTH_LOG2(4)) u_fifo
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(wr_valid_i),
      .in_ready_o(wr_ready_o),
      .in_data_i({wr_first_i, loaded_sample_count_i, waveform_label_i, wr_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(1'b1),
      .out_data_o(f_data)
   );
   wire [SW-1:0] f_smp = f_data[SW-1:0];
   wire [NLBL_LOG2-1:0] f_lbl = f_data[SW+NLBL_LOG2-1:SW];
   wire [AW:0] f_cnt = f_data[SW+NLBL_LOG2+AW:SW+NLBL_LOG2];
   wire f_first = f_data[SW+NLBL_LOG2+AW+1];
   wire [NLBL_LOG2-1:0] cur_lbl = f_first ? f_lbl : lbl_r;
   wire pause_w = p1_r;
   wire stop_ev = done_i | pause_w | underflow_i;
   // ----------------------------------------
   // build a pattern from a configuration request
   // ----------------------------------------
   reg [NCH*`PGCS_ST_W-1:0] new_pat;
   reg [3:0] ch;
   always @*
   begin
      ch = 4'h0;
      new_pat = cfg_sel_i ? start_pend_r : stop_pend_r;
      // own loop variable: one driver per variable across processes
      for (ci = 0; ci < NCH; ci = ci + 1)
      begin
         if (ci < cfg_len_i)
         begin
            ch = channel_selection_i[ci*4 +: 4];
            if (cfg_mask_form_i)
               new_pat[ch*2 +: 2] = cfg_mask_i[ci] ? `PGCS_ST_HIGH : `PGCS_ST_LOW;
            else
               new_pat[ch*2 +: 2] = eff_code(cfg_codes_i[ci*2 +: 2]);
         end
      end
   end
   // ----------------------------------------
   // configuration, commit and generation state
   // ----------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stop_pend_r <= {NCH{`PGCS_ST_HOLD}};
         start_pend_r <= {NCH{`PGCS_ST_HOLD}};
         stop_act_r <= {NCH{`PGCS_ST_HOLD}};
         start_act_r <= {NCH{`PGCS_ST_HOLD}};
         rate_pend_r <= {RW{1'b0}};
         active_rate_o <= {RW{1'b0}};
         cfg_err_o <= 1'b0;
         p0_r <= 1'b0;
         p1_r <= 1'b0;
         gst_r <= `PGCS_G_IDLE;
         gen_state_o <= `PGCS_G_IDLE;
         ch_o <= {NCH{1'b0}};
         ch_oe_o <= {NCH{1'b0}};
      end
      else if (ce_i)
      begin
         p0_r <= pause_i;
         p1_r <= p0_r;
         cfg_err_o <= 1'b0;
         if (cfg_wr_i)
         begin
            if (cfg_len_i != sel_count_i)
               cfg_err_o <= 1'b1;
            else if (cfg_sel_i)
               start_pend_r <= new_pat;
            else
               stop_pend_r <= new_pat;
         end
         // override by loaded waveform rate
         rate_pend_r <= file_rate_flag_i ? file_rate_i : rate_cfg_i;
         if (commit_i)
         begin
            stop_act_r <= stop_pend_r;
            start_act_r <= start_pend_r;
            active_rate_o <= rate_pend_r;
         end
         case (gst_r)
            `PGCS_G_IDLE:
               if (start_i)
                  gst_r <= `PGCS_G_START;
            `PGCS_G_START:
               if (stop_ev)
                  gst_r <= `PGCS_G_IDLE;
               else if (smp_valid_i)
                  gst_r <= `PGCS_G_RUN;
            `PGCS_G_RUN:
               if (stop_ev)
                  gst_r <= `PGCS_G_IDLE;
            default:
               gst_r <= `PGCS_G_IDLE;
         endcase
         gen_state_o <= gst_r;
         // drive channels from state
         for (i = 0; i < NCH; i = i + 1)
         begin
            if (gst_r == `PGCS_G_RUN && !stop_ev && smp_valid_i)
            begin
               ch_o[i] <= smp_i[i];
               ch_oe_o[i] <= 1'b1;
            end
            else if (gst_r != `PGCS_G_RUN || stop_ev)
            begin
               // startup levels while waiting, stopped levels otherwise
               case ((gst_r == `PGCS_G_START && !stop_ev) ?
                  start_act_r[i*2 +: 2] : stop_act_r[i*2 +: 2])
                  `PGCS_ST_HIGH:
                  begin
                     ch_o[i] <= 1'b1;
                     ch_oe_o[i] <= 1'b1;
                  end
                  `PGCS_ST_LOW:
                  begin
                     ch_o[i] <= 1'b0;
                     ch_oe_o[i] <= 1'b1;
                  end
                  `PGCS_ST_OFF:
                     ch_oe_o[i] <= 1'b0;
                  default:
                     ch_o[i] <= ch_o[i];
               endcase
            end
         end
      end
   end
   // ----------------------------------------
   // waveform allocation and write pointer
   // ----------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alloc_r <= {NL{1'b0}};
         free_r <= {(AW+1){1'b0}};
         lbl_r <= {NLBL_LOG2{1'b0}};
         refuse_r <= 1'b0;
         wr_err_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_addr_o <= {AW{1'b0}};
         mem_data_o <= {SW{1'b0}};
         wr_ptr_o <= {(AW+1){1'b0}};
         for (li = 0; li < NL; li = li + 1)
         begin
            base_r[li] <= {(AW+1){1'b0}};
            size_r[li] <= {(AW+1){1'b0}};
            ptr_r[li] <= {(AW+1){1'b0}};
         end
      end
      else if (ce_i)
      begin
         mem_we_o <= 1'b0;
         wr_err_o <= 1'b0;
         wr_ptr_o <= ptr_r[lbl_r];
         if (f_valid)
         begin
            if (f_first)
            begin
               lbl_r <= f_lbl;
               if (!alloc_r[f_lbl])
               begin
                  if (MEM_TOP - free_r >= f_cnt)
                  begin
                     alloc_r[f_lbl] <= 1'b1;
                     base_r[f_lbl] <= free_r;
                     size_r[f_lbl] <= f_cnt;
                     ptr_r[f_lbl] <= {{AW{1'b0}}, 1'b1};
                     free_r <= free_r + f_cnt;
                     refuse_r <= 1'b0;
                     mem_we_o <= 1'b1;
                     mem_addr_o <= free_r[AW-1:0];
                     mem_data_o <= f_smp;
                  end
                  else
                  begin
                     refuse_r <= 1'b1;
                     wr_err_o <= 1'b1;
                  end
               end
               // extra top bit so a huge count cannot wrap past the limit
               else if ({1'b0, ptr_r[f_lbl]} + {1'b0, f_cnt} > {1'b0, size_r[f_lbl]})
               begin
                  refuse_r <= 1'b1;
                  wr_err_o <= 1'b1;
               end
               else
               begin
                  refuse_r <= 1'b0;
                  mem_we_o <= 1'b1;
                  mem_addr_o <= base_r[f_lbl][AW-1:0] + ptr_r[f_lbl][AW-1:0];
                  mem_data_o <= f_smp;
                  ptr_r[f_lbl] <= ptr_r[f_lbl] + 1'b1;
               end
            end
            else if (!refuse_r && ptr_r[cur_lbl] < size_r[cur_lbl])
            begin
               mem_we_o <= 1'b1;
               mem_addr_o <= base_r[cur_lbl][AW-1:0] + ptr_r[cur_lbl][AW-1:0];
               mem_data_o <= f_smp;
               ptr_r[cur_lbl] <= ptr_r[cur_lbl] + 1'b1;
            end
         end
      end
   end
endmodule // pgcs_ctrl

// ==== include/pgcs_consts.vh ====
`ifndef PGCS_CONSTS_VH
`define PGCS_CONSTS_VH
// ----------------------------------------
// channel state codes, two bits per channel
// ----------------------------------------
`define PGCS_ST_LOW 2'h0
`define PGCS_ST_HIGH 2'h1
`define PGCS_ST_HOLD 2'h2
`define PGCS_ST_OFF 2'h3
`define PGCS_ST_W 2
// ----------------------------------------
// generation states
// ----------------------------------------
`define PGCS_G_IDLE 2'h0
`define PGCS_G_START 2'h1
`define PGCS_G_RUN 2'h2
`endif

// ==== src/pgcs_fifo.v ====
`timescale 1ns/100ps
// ----------------------------------------
// small synchronous fifo, valid/ready both sides
// ----------------------------------------
module pgcs_fifo
#(
   parameter WIDTH = 16,
   parameter DEPTH_LOG2 = 4
)
(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage words
   reg [DEPTH_LOG2:0] wp_r; // write pointer, extra wrap bit
   reg [DEPTH_LOG2:0] rp_r; // read pointer, extra wrap bit
   wire full_w;
   wire empty_w;
   wire push_w;
   wire pop_w;
   assign empty_w = (wp_r == rp_r);
   assign full_w = (wp_r[DEPTH_LOG2-1:0] == rp_r[DEPTH_LOG2-1:0]) &&
      (wp_r[DEPTH_LOG2] != rp_r[DEPTH_LOG2]);
   assign in_ready_o = ~full_w;
   assign out_valid_o = ~empty_w;
   assign push_w = ce_i & in_valid_i & ~full_w;
   assign pop_w = ce_i & out_ready_i & ~empty_w;
   // head word read straight from the array
   assign out_data_o = mem_r[rp_r[DEPTH_LOG2-1:0]];
   // ----------------------------------------
   // pointer and storage update
   // ----------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp_r <= {(DEPTH_LOG2+1){1'b0}};
         rp_r <= {(DEPTH_LOG2+1){1'b0}};
      end
      else
      begin
         if (push_w)
         begin
            mem_r[wp_r[DEPTH_LOG2-1:0]] <= in_data_i;
            wp_r <= wp_r + 1'b1;
         end
         if (pop_w)
            rp_r <= rp_r + 1'b1;
      end
   end
endmodule // pgcs_fifo

// ==== bench/pgcs_dut_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// far-side pins, no pull resistor
// ----------------------------------------
module pgcs_dut_model
#(
   parameter NCH = 4
)
(
   input wire clk_i,
   input wire [NCH-1:0] ch_i,
   input wire [NCH-1:0] oe_i,
   output logic [NCH-1:0] pin_o
);
   logic [NCH-1:0] last_r = '0; // level seen last cycle
   always @(posedge clk_i)
   begin
      last_r <= pin_o;
   end
   // a released pin toggles so it never looks driven
   assign pin_o = (ch_i & oe_i) | (~last_r & ~oe_i);
endmodule // pgcs_dut_model

// ==== bench/pgcs_ctrl_assertions.sv ====
`timescale 1ns/100ps
`include "pgcs_consts.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module pgcs_ctrl_chk
#(
   parameter NCH = 8,
   parameter AW = 10,
   parameter RW = 32
)
(
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire cfg_wr_i,
   input wire [4:0] cfg_len_i,
   input wire [4:0] sel_count_i,
   input wire cfg_err_o,
   input wire [RW-1:0] rate_cfg_i,
   input wire [RW-1:0] file_rate_i,
   input wire file_rate_flag_i,
   input wire [RW-1:0] active_rate_o,
   input wire commit_i,
   input wire start_i,
   input wire done_i,
   input wire underflow_i,
   input wire smp_valid_i,
   input wire [NCH-1:0] ch_o,
   input wire [NCH-1:0] ch_oe_o,
   input wire [1:0] gen_state_o,
   input wire wr_err_o,
   input wire mem_we_o,
   input wire [AW-1:0] mem_addr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // state changes land within three cycles
   sequence s_start;
      ##[1:3] gen_state_o == `PGCS_G_START;
   endsequence
   sequence s_idle;
      ##[1:3] gen_state_o == `PGCS_G_IDLE;
   endsequence
   property p_len;
      ce_i && cfg_wr_i |=> cfg_err_o == ($past(cfg_len_i) != $past(sel_count_i));
   endproperty
   a_len: assert property (p_len) else $error("length error wrong");
   property p_rate;
      ce_i && $past(ce_i) && commit_i |=> active_rate_o ==
         ($past(file_rate_flag_i, 2) ? $past(file_rate_i, 2) : $past(rate_cfg_i, 2));
   endproperty
   a_rate: assert property (p_rate) else $error("rate source wrong");
   property p_keep;
      !commit_i |=> $stable(active_rate_o);
   endproperty
   a_keep: assert property (p_keep) else $error("rate moved without commit");
   property p_start;
      ce_i && start_i && gen_state_o == `PGCS_G_IDLE |-> s_start;
   endproperty
   a_start: assert property (p_start) else $error("no startup phase");
   property p_stop;
      (done_i || underflow_i) && gen_state_o == `PGCS_G_RUN |-> s_idle;
   endproperty
   a_stop: assert property (p_stop) else $error("generation did not stop");
   property p_hold;
      (gen_state_o == `PGCS_G_START && !smp_valid_i) [*3] |-> $stable({ch_oe_o, ch_o});
   endproperty
   a_hold: assert property (p_hold) else $error("startup level moved");
   property p_seq;
      mem_we_o && $past(mem_we_o) |-> mem_addr_o == $past(mem_addr_o) + 1'b1;
   endproperty
   a_seq: assert property (p_seq) else $error("write address skipped");
   property p_refuse;
      wr_err_o |-> !mem_we_o [*2];
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused write stored");
endmodule // pgcs_ctrl_chk
bind pgcs_ctrl pgcs_ctrl_chk #(.NCH(NCH), .AW(AW), .RW(RW)) u_pgcs_ctrl_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_wr_i(cfg_wr_i), .cfg_len_i(cfg_len_i),
   .sel_count_i(sel_count_i), .cfg_err_o(cfg_err_o), .rate_cfg_i(rate_cfg_i),
   .file_rate_i(file_rate_i), .file_rate_flag_i(file_rate_flag_i),
   .active_rate_o(active_rate_o), .commit_i(commit_i), .start_i(start_i), .done_i(done_i),
   .underflow_i(underflow_i), .smp_valid_i(smp_valid_i), .ch_o(ch_o), .ch_oe_o(ch_oe_o),
   .gen_state_o(gen_state_o), .wr_err_o(wr_err_o), .mem_we_o(mem_we_o),
   .mem_addr_o(mem_addr_o));

// ==== bench/pgcs_ctrl_test.sv ====
`timescale 1ns/100ps
`include "pgcs_consts.vh"
// ----------------------------------------
// bench: patterns, stops, rate, writes
// ----------------------------------------
module pgcs_ctrl_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic cfg_wr_i = 1'b0, cfg_sel_i = 1'b0, cfg_mask_form_i = 1'b0, smp_valid_i = 1'b0;
   logic [7:0] cfg_codes_i = 8'h00, rate_cfg_i = 8'h00, file_rate_i = 8'h00, act = 8'h00;
   logic [3:0] cfg_mask_i = 4'h0, wr_data_i = 4'h0, smp_i = 4'h0;
   logic [15:0] channel_selection_i = 16'h0123; // position i drives channel 3-i
   logic [4:0] cfg_len_i = 5'h04, sel_count_i = 5'h04;
   logic file_rate_flag_i = 1'b0, commit_i = 1'b0, start_i = 1'b0, done_i = 1'b0;
   logic pause_i = 1'b0, underflow_i = 1'b0, wr_valid_i = 1'b0, wr_first_i = 1'b0;
   logic [1:0] waveform_label_i = 2'h0;
   logic [6:0] loaded_sample_count_i = 7'h00;
   wire cfg_err_o, wr_ready_o, wr_err_o, mem_we_o;
   wire [7:0] active_rate_o;
   wire [5:0] mem_addr_o;
   wire [3:0] mem_data_o, ch_o, ch_oe_o, pin;
   wire [6:0] wr_ptr_o;
   wire [1:0] gen_state_o;
   integer err_total = 0, check_count = 0, werr = 0, k;
   logic [5:0] ga[$], ea[$];
   logic [3:0] gd[$], ed[$];
   pgcs_ctrl #(.NCH(4), .SW(4), .AW(6), .NLBL_LOG2(2), .HAS_OFF(1), .RW(8)) u_pgcs_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cfg_wr_i(cfg_wr_i), .cfg_sel_i(cfg_sel_i),
      .cfg_mask_form_i(cfg_mask_form_i), .cfg_codes_i(cfg_codes_i), .cfg_mask_i(cfg_mask_i),
      .channel_selection_i(channel_selection_i), .cfg_len_i(cfg_len_i),
      .sel_count_i(sel_count_i), .cfg_err_o(cfg_err_o), .rate_cfg_i(rate_cfg_i),
      .file_rate_i(file_rate_i), .file_rate_flag_i(file_rate_flag_i),
      .active_rate_o(active_rate_o), .commit_i(commit_i), .start_i(start_i), .done_i(done_i),
      .pause_i(pause_i), .underflow_i(underflow_i), .wr_valid_i(wr_valid_i),
      .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .waveform_label_i(waveform_label_i),
      .wr_first_i(wr_first_i), .loaded_sample_count_i(loaded_sample_count_i),
      .wr_err_o(wr_err_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
      .mem_we_o(mem_we_o), .wr_ptr_o(wr_ptr_o), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
      .ch_o(ch_o), .ch_oe_o(ch_oe_o), .gen_state_o(gen_state_o));
   pgcs_dut_model #(.NCH(4)) u_pgcs_dut_model (.clk_i(clk_i), .ch_i(ch_o), .oe_i(ch_oe_o),
      .pin_o(pin));
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   // memory write monitor
   always @(posedge clk_i)
   begin
      if (mem_we_o === 1'b1) ga.push_back(mem_addr_o);
      if (mem_we_o === 1'b1) gd.push_back(mem_data_o);
      if (wr_err_o === 1'b1) werr++;
   end
   task automatic wt(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected {enable, level} after codes over a driven level
   // position i lands on the channel named by cs[4*i+:4]
   function automatic logic [7:0] exp_pins(input logic [7:0] c, input logic [3:0] l,
      input logic [15:0] cs);
      logic [3:0] e;
      integer i;
      e = 4'hf;
      for (i = 0; i < 4; i++)
      begin
         if (c[2*i+:2] == `PGCS_ST_OFF) e[cs[4*i+:2]] = 1'b0;
         if (c[2*i+:2] < `PGCS_ST_HOLD) l[cs[4*i+:2]] = c[2*i];
      end
      return {e, l & e};
   endfunction
   task automatic cfg(input logic s, input logic m, input logic [7:0] c, input logic [4:0] n,
      input logic [4:0] q);
      @(posedge clk_i);
      {cfg_wr_i, cfg_sel_i, cfg_mask_form_i, cfg_codes_i, cfg_mask_i, cfg_len_i, sel_count_i} <=
         {1'b1, s, m, c, c[3:0], n, q};
      @(posedge clk_i);
      cfg_wr_i <= 1'b0;
      #1 chk(cfg_err_o, n != q);
   endtask
   // one-cycle pulse on commit, start, done, underflow
   task automatic go(input logic [3:0] v);
      @(posedge clk_i);
      {commit_i, start_i, done_i, underflow_i} <= v;
      @(posedge clk_i);
      {commit_i, start_i, done_i, underflow_i} <= 4'h0;
   endtask
   task automatic run_once(input integer k);
      logic [7:0] sc, r, mc;
      logic [3:0] m, s;
      integer j;
      sc = (k == 0) ? 8'he4 : 8'($urandom);
      m = $urandom;
      s = $urandom;
      r = $urandom;
      // mask form restated as low/high codes for the expectation
      for (j = 0; j < 4; j++) mc[2*j+:2] = {1'b0, m[j]};
      // channel order drawn at random: straight or reversed
      @(posedge clk_i);
      channel_selection_i <= r[7] ? 16'h3210 : 16'h0123;
      cfg(1'b0, 1'b0, sc, 5'h04, 5'h04);
      cfg(1'b0, 1'b0, 8'h00, 5'h03, 5'h04);
      cfg(1'b0, 1'b0, 8'h00, 5'h04, 5'h05 + 5'(k));
      cfg(1'b1, 1'b1, {4'h0, m}, 5'h04, 5'h04);
      @(posedge clk_i);
      {rate_cfg_i, file_rate_i, file_rate_flag_i} <= {r, ~r, k[0]};
      wt(3);
      chk(active_rate_o, act);
      go(4'h8);
      wt(1);
      act = k[0] ? ~r : r;
      chk(active_rate_o, act);
      go(4'h4);
      wt(4);
      chk({ch_oe_o, pin}, exp_pins(mc, 4'h0, channel_selection_i));
      wt(3);
      chk({ch_oe_o, pin}, exp_pins(mc, 4'h0, channel_selection_i));
      @(posedge clk_i);
      {smp_valid_i, smp_i} <= {1'b1, s};
      wt(3);
      chk({ch_oe_o, pin}, {4'hf, s});
      @(posedge clk_i);
      {smp_valid_i, pause_i, done_i, underflow_i} <= {1'b0, k % 3 == 1, k % 3 == 0, k % 3 == 2};
      @(posedge clk_i);
      {done_i, underflow_i} <= 2'b00;
      wt(4);
      chk({ch_oe_o, pin & ch_oe_o}, exp_pins(sc, s, channel_selection_i));
      @(posedge clk_i);
      pause_i <= 1'b0;
      go(4'h2);
      wt(3);
   endtask
   task automatic wr(input logic [1:0] lb, input integer n, input logic [6:0] c,
      input logic [5:0] a, input logic ok);
      integer i;
      logic [3:0] d;
      @(posedge clk_i);
      for (i = 0; i < n; i++)
      begin
         d = $urandom;
         {wr_valid_i, wr_first_i, waveform_label_i, loaded_sample_count_i, wr_data_i} <=
            {1'b1, i == 0, lb, c, d};
         if (ok) ea.push_back(a + i[5:0]);
         if (ok) ed.push_back(d);
         @(negedge clk_i);
         while (wr_ready_o !== 1'b1) @(negedge clk_i);
         @(posedge clk_i);
      end
      wr_valid_i <= 1'b0;
      wt(4);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'hcab0));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      // frozen by the clock enable: a start pulse must be ignored
      @(posedge clk_i);
      ce_i <= 1'b0;
      go(4'h4);
      wt(2);
      chk(gen_state_o, `PGCS_G_IDLE);
      @(posedge clk_i);
      ce_i <= 1'b1;
      go(4'h4);
      wt(4);
      chk({ch_oe_o, ch_o}, 8'h00);
      go(4'h2);
      wt(3);
      for (k = 0; k < 6; k++) run_once(k);
      wr(2'h0, 3, 7'h03, 6'h00, 1'b1);
      chk(wr_ptr_o, 7'h03);
      wr(2'h0, 1, 7'h01, 6'h00, 1'b0);
      chk(wr_ptr_o, 7'h03);
      wr(2'h1, 4, 7'h04, 6'h03, 1'b1);
      chk(wr_ptr_o, 7'h04);
      wr(2'h2, 2, 7'h3c, 6'h00, 1'b0);
      chk(werr, 2);
      chk(ga.size(), ea.size());
      for (k = 0; k < ea.size() && k < ga.size(); k++) chk({ga[k], gd[k]}, {ea[k], ed[k]});
      close_out;
   end
   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      close_out;
   end
endmodule // pgcs_ctrl_test
